/* hw/pemp_params.svh */
`ifndef PEMP_PARAMS_SVH
`define PEMP_PARAMS_SVH
// ****************************************
// device register indexes
// ****************************************
`define PEMP_IDX_CSEL     8'h1a
`define PEMP_IDX_PTR      8'h2c
`define PEMP_IDX_PIX      8'h2d
`define PEMP_IDX_LOOP     8'h2f
`define PEMP_IDX_MLCC     8'h39
// ****************************************
// pointer positions and field values
// ****************************************
`define PEMP_PTR_N        8'h00
`define PEMP_PTR_P        8'h2a
`define PEMP_PTR_ST       8'h3f
`define PEMP_CSEL_QUIET   8'h75
`define PEMP_CSEL_PLAIN   8'h05
`define PEMP_RUN_OFF      8'h00
`define PEMP_N_TOP        8'hc0
`define PEMP_PIX_P_BASE   8'hb0
`define PEMP_LOOP_P_BASE  8'hf0
`define PEMP_MLCC_BASE    8'h30
`define PEMP_LOCK_BIT     6
`define PEMP_SEL_STOP     2'h3
`define PEMP_SEL_RESET    2'h0
// ****************************************
// loop pll divider pairs per pixel depth
// ****************************************
`define PEMP_LN_8         8'he1
`define PEMP_LN_16        8'hf1
`define PEMP_LN_WIDE      8'hf9
`define PEMP_LM_STD       8'h3d
`define PEMP_LM_24        8'hbe
// ****************************************
// pixel clock bands for loop post-divider
// ****************************************
`define PEMP_BAND_HI      9'h0af
`define PEMP_BAND_MID     9'h06e
`define PEMP_BAND_LO      9'h046
// ****************************************
// timing
// ****************************************
`define PEMP_CLK_MHZ      200
`define PEMP_STOP_NS      1000
`define PEMP_GAP_NS       500
`define PEMP_LOCK_TMO_US  5000
`define PEMP_STOP_CYC     ((`PEMP_STOP_NS * `PEMP_CLK_MHZ + 999) / 1000)
`define PEMP_GAP_CYC      ((`PEMP_GAP_NS * `PEMP_CLK_MHZ + 999) / 1000)
`define PEMP_LOCK_TMO_CYC (`PEMP_LOCK_TMO_US * `PEMP_CLK_MHZ)
`endif

/* hw/pemp_pkg.sv */
`default_nettype none
package pemp_pkg;

  // ****************************************
  // sequencer states, one-hot
  // ****************************************
  typedef enum logic [20:0] {
    S_IDLE     = 21'h000001,
    S_CSEL     = 21'h000002,
    S_PTR_P    = 21'h000004,
    S_LOOP_OFF = 21'h000008,
    S_PIX_OFF  = 21'h000010,
    S_STOP     = 21'h000020,
    S_PTR_N1   = 21'h000040,
    S_PIX_N    = 21'h000080,
    S_PIX_M    = 21'h000100,
    S_PIX_P    = 21'h000200,
    S_PTR_ST1  = 21'h000400,
    S_POLL     = 21'h000800,
    S_RDWAIT   = 21'h001000,
    S_CHECK    = 21'h002000,
    S_GAP      = 21'h004000,
    S_MLCC     = 21'h008000,
    S_PTR_N2   = 21'h010000,
    S_LOOP_N   = 21'h020000,
    S_LOOP_M   = 21'h040000,
    S_LOOP_P   = 21'h080000,
    S_PTR_ST2  = 21'h100000
  } pemp_state_type;

  // ****************************************
  // pixel depth selection
  // ****************************************
  typedef enum logic [1:0] {
    DEPTH_8  = 2'h0,
    DEPTH_16 = 2'h1,
    DEPTH_24 = 2'h2,
    DEPTH_32 = 2'h3
  } pemp_depth_type;

  // ****************************************
  // sequencer state record
  // ****************************************
  typedef struct packed {
    pemp_state_type st;
    logic           phase_loop;
    logic [7:0]     cnt;
    logic [7:0]     addr;
    logic [7:0]     wdata;
    logic           wr;
    logic           rd;
    logic [1:0]     sel;
    logic           busy;
    logic           done;
    logic           fail;
    logic           fail_loop;
    logic [7:0]     pn;
    logic [7:0]     pm;
    logic [1:0]     pp;
    pemp_depth_type depth;
    logic [8:0]     mhz;
    logic           quiet;
  } pemp_ctl_type;

  // ****************************************
  // lock timeout record
  // ****************************************
  typedef struct packed {
    logic [19:0] cnt;
    logic        expired;
  } pemp_timer_type;

endpackage : pemp_pkg
`default_nettype wire

/* hw/pemp_lock_timer.sv */
`include "pemp_params.svh"
`default_nettype none
module pemp_lock_timer #(
  parameter int unsigned LIMIT = `PEMP_LOCK_TMO_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // control
  input  wire logic restart,
  output logic      expired
);

  pemp_pkg::pemp_timer_type q;
  pemp_pkg::pemp_timer_type d;

  // ****************************************
  // bounded lock wait
  // ****************************************
  always_comb
  begin
    d = q;
    if (restart)
    begin
      d.cnt     = 20'h00000;
      d.expired = 1'b0;
    end
    else if (q.cnt >= 20'(LIMIT - 1))
      d.expired = 1'b1;
    else
      d.cnt = q.cnt + 20'h00001;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      q <= '0;
    else
      q <= d;
  end

  assign expired = q.expired;

endmodule : pemp_lock_timer
`default_nettype wire

/* hw/pemp_loop_table.sv */
`include "pemp_params.svh"
`default_nettype none
module pemp_loop_table (
  // request
  input  wire pemp_pkg::pemp_depth_type depth,
  input  wire logic [8:0]               mhz,
  // loop pll values
  output logic [7:0]                    loop_n,
  output logic [7:0]                    loop_m,
  output logic [7:0]                    loop_p,
  output logic [7:0]                    mlcc
);

  logic [1:0] post;

  // ****************************************
  // divider pair by depth
  // ****************************************
  always_comb
  begin
    loop_m = `PEMP_LM_STD;
    case (depth)
      pemp_pkg::DEPTH_8:  loop_n = `PEMP_LN_8;
      pemp_pkg::DEPTH_16: loop_n = `PEMP_LN_16;
      pemp_pkg::DEPTH_24:
      begin
        loop_n = `PEMP_LN_WIDE;
        loop_m = `PEMP_LM_24;
      end
      pemp_pkg::DEPTH_32: loop_n = `PEMP_LN_WIDE;
      default:            loop_n = `PEMP_LN_8;
    endcase
  end

  // ****************************************
  // post-divider by pixel clock band
  // ****************************************
  always_comb
  begin
    if (mhz >= `PEMP_BAND_HI)
      post = 2'h0;
    else if (mhz >= `PEMP_BAND_MID)
      post = 2'h1;
    else if (mhz >= `PEMP_BAND_LO)
      post = 2'h2;
    else
      post = 2'h3;
    loop_p = `PEMP_LOOP_P_BASE | {6'h00, post};
    mlcc   = `PEMP_MLCC_BASE | {6'h00, post};
  end

endmodule : pemp_loop_table
`default_nettype wire

/* hw/pemp_host.sv */
`include "pemp_params.svh"
`default_nettype none
module pemp_host #(
  parameter int unsigned LOCK_TMO_CYC = `PEMP_LOCK_TMO_CYC
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     srst,
  // user command
  input  wire logic                     start,
  input  wire pemp_pkg::pemp_depth_type depth_sel,
  input  wire logic [8:0]               pix_mhz,
  input  wire logic [7:0]               pix_n,
  input  wire logic [7:0]               pix_m,
  input  wire logic [1:0]               pix_p,
  input  wire logic                     quiet_video_clock,
  // user status
  output logic                          busy,
  output logic                          done,
  output logic                          fail,
  output logic                          fail_loop,
  // device register access
  output logic [7:0]                    dev_index,
  output logic [7:0]                    dev_wdata,
  output logic                          dev_wr,
  output logic                          dev_rd,
  input  wire logic [7:0]               dev_rdata,
  // device clock select pins
  output logic [1:0]                    pll_source_select_inputs
);

  pemp_pkg::pemp_ctl_type q;
  pemp_pkg::pemp_ctl_type d;
  logic                   restart;
  logic                   expired;
  logic [7:0]             loop_n;
  logic [7:0]             loop_m;
  logic [7:0]             loop_p;
  logic [7:0]             mlcc;

  // ****************************************
  // helpers
  // ****************************************
  pemp_lock_timer #(
    .LIMIT   (LOCK_TMO_CYC)
  ) u_timer (
    .clk     (clk),
    .srst    (srst),
    .restart (restart),
    .expired (expired)
  );

  pemp_loop_table u_table (
    .depth   (q.depth),
    .mhz     (q.mhz),
    .loop_n  (loop_n),
    .loop_m  (loop_m),
    .loop_p  (loop_p),
    .mlcc    (mlcc)
  );

  // ****************************************
  // programming sequence
  // ****************************************
  always_comb
  begin
    d       = q;
    d.wr    = 1'b0;
    d.rd    = 1'b0;
    d.done  = 1'b0;
    d.fail  = 1'b0;
    restart = 1'b0;
    case (q.st)
      pemp_pkg::S_IDLE:
      begin
        if (start)
        begin
          d.busy      = 1'b1;
          d.fail_loop = 1'b0;
          d.pn        = pix_n;
          d.pm        = pix_m;
          d.pp        = pix_p;
          d.depth     = depth_sel;
          d.mhz       = pix_mhz;
          d.quiet     = quiet_video_clock;
          d.st        = pemp_pkg::S_CSEL;
        end
      end
      pemp_pkg::S_CSEL:
      begin
        d.wr    = 1'b1;
        d.addr  = `PEMP_IDX_CSEL;
        if (q.quiet)
          d.wdata = `PEMP_CSEL_QUIET;
        else
          d.wdata = `PEMP_CSEL_PLAIN;
        d.st    = pemp_pkg::S_PTR_P;
      end
      pemp_pkg::S_PTR_P:
      begin
        d.wr    = 1'b1;
        d.addr  = `PEMP_IDX_PTR;
        d.wdata = `PEMP_PTR_P;
        d.st    = pemp_pkg::S_LOOP_OFF;
      end
      pemp_pkg::S_LOOP_OFF:
      begin
        d.wr    = 1'b1;
        d.addr  = `PEMP_IDX_LOOP;
        d.wdata = `PEMP_RUN_OFF;
        d.st    = pemp_pkg::S_PIX_OFF;
      end
      pemp_pkg::S_PIX_OFF:
      begin
        d.wr    = 1'b1;
        d.addr  = `PEMP_IDX_PIX;
        d.wdata = `PEMP_RUN_OFF;
        d.cnt   = 8'h00;
        d.st    = pemp_pkg::S_STOP;
      end
      pemp_pkg::S_STOP:
      begin
        d.sel = `PEMP_SEL_STOP;
        if (q.cnt >= 8'(`PEMP_STOP_CYC - 1))
          d.st = pemp_pkg::S_PTR_N1;
        else
          d.cnt = q.cnt + 8'h01;
      end
      pemp_pkg::S_PTR_N1:
      begin
        d.wr    = 1'b1;
        d.addr  = `PEMP_IDX_PTR;
        d.wdata = `PEMP_PTR_N;
        d.st    = pemp_pkg::S_PIX_N;
      end
      pemp_pkg::S_PIX_N:
      begin
        d.wr    = 1'b1;
        d.addr  = `PEMP_IDX_PIX;
        d.wdata = q.pn | `PEMP_N_TOP;
        d.st    = pemp_pkg::S_PIX_M;
      end
      pemp_pkg::S_PIX_M:
      begin
        d.wr    = 1'b1;
        d.addr  = `PEMP_IDX_PIX;
        d.wdata = q.pm;
        d.st    = pemp_pkg::S_PIX_P;
      end
      pemp_pkg::S_PIX_P:
      begin
        d.wr    = 1'b1;
        d.addr  = `PEMP_IDX_PIX;
        d.wdata = `PEMP_PIX_P_BASE | {6'h00, q.pp};
        d.st    = pemp_pkg::S_PTR_ST1;
      end
      pemp_pkg::S_PTR_ST1:
      begin
        d.wr         = 1'b1;
        d.addr       = `PEMP_IDX_PTR;
        d.wdata      = `PEMP_PTR_ST;
        d.phase_loop = 1'b0;
        restart      = 1'b1;
        d.st         = pemp_pkg::S_POLL;
      end
      pemp_pkg::S_POLL:
      begin
        d.rd = 1'b1;
        if (q.phase_loop)
          d.addr = `PEMP_IDX_LOOP;
        else
          d.addr = `PEMP_IDX_PIX;
        d.st = pemp_pkg::S_RDWAIT;
      end
      pemp_pkg::S_RDWAIT:
      begin
        d.st = pemp_pkg::S_CHECK;
      end
      pemp_pkg::S_CHECK:
      begin
        d.cnt = 8'h00;
        if (dev_rdata[`PEMP_LOCK_BIT])
        begin
          if (q.phase_loop)
          begin
            d.busy = 1'b0;
            d.done = 1'b1;
            d.st   = pemp_pkg::S_IDLE;
          end
          else
            d.st = pemp_pkg::S_MLCC;
        end
        else if (expired)
        begin
          d.busy      = 1'b0;
          d.fail      = 1'b1;
          d.fail_loop = q.phase_loop;
          d.st        = pemp_pkg::S_IDLE;
        end
        else
          d.st = pemp_pkg::S_GAP;
      end
      pemp_pkg::S_GAP:
      begin
        if (q.cnt >= 8'(`PEMP_GAP_CYC - 1))
          d.st = pemp_pkg::S_POLL;
        else
          d.cnt = q.cnt + 8'h01;
      end
      pemp_pkg::S_MLCC:
      begin
        d.wr    = 1'b1;
        d.addr  = `PEMP_IDX_MLCC;
        d.wdata = mlcc;
        d.st    = pemp_pkg::S_PTR_N2;
      end
      pemp_pkg::S_PTR_N2:
      begin
        d.wr    = 1'b1;
        d.addr  = `PEMP_IDX_PTR;
        d.wdata = `PEMP_PTR_N;
        d.st    = pemp_pkg::S_LOOP_N;
      end
      pemp_pkg::S_LOOP_N:
      begin
        d.wr    = 1'b1;
        d.addr  = `PEMP_IDX_LOOP;
        d.wdata = loop_n;
        d.st    = pemp_pkg::S_LOOP_M;
      end
      pemp_pkg::S_LOOP_M:
      begin
        d.wr    = 1'b1;
        d.addr  = `PEMP_IDX_LOOP;
        d.wdata = loop_m;
        d.st    = pemp_pkg::S_LOOP_P;
      end
      pemp_pkg::S_LOOP_P:
      begin
        d.wr    = 1'b1;
        d.addr  = `PEMP_IDX_LOOP;
        d.wdata = loop_p;
        d.st    = pemp_pkg::S_PTR_ST2;
      end
      pemp_pkg::S_PTR_ST2:
      begin
        d.wr         = 1'b1;
        d.addr       = `PEMP_IDX_PTR;
        d.wdata      = `PEMP_PTR_ST;
        d.phase_loop = 1'b1;
        restart      = 1'b1;
        d.st         = pemp_pkg::S_POLL;
      end
      default:
      begin
        d.busy = 1'b0;
        d.st   = pemp_pkg::S_IDLE;
      end
    endcase
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      q       <= '0;
      q.st    <= pemp_pkg::S_IDLE;
      q.sel   <= `PEMP_SEL_RESET;
      q.depth <= pemp_pkg::DEPTH_8;
    end
    else
      q <= d;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign busy                     = q.busy;
  assign done                     = q.done;
  assign fail                     = q.fail;
  assign fail_loop                = q.fail_loop;
  assign dev_index                = q.addr;
  assign dev_wdata                = q.wdata;
  assign dev_wr                   = q.wr;
  assign dev_rd                   = q.rd;
  assign pll_source_select_inputs = q.sel;

endmodule : pemp_host
`default_nettype wire

/* sim/pemp_dev_model.sv */
`default_nettype none
module pemp_dev_model #(
  parameter int unsigned SLOW_CYC = 150
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // register access
  input  wire logic [7:0] dev_index,
  input  wire logic [7:0] dev_wdata,
  input  wire logic       dev_wr,
  input  wire logic       dev_rd,
  output var  logic [7:0] dev_rdata,
  // pins and lock controls
  input  wire logic [1:0] pll_sel,
  input  wire logic [1:0] hold_lock,
  input  wire logic       slow
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // pll registers, 0 pixel 1 loop
  // ****************************************
  logic [1:0] pos  [2];
  logic [5:0] n6   [2];
  logic [7:0] m    [2];
  logic [7:0] p    [2];
  logic [7:0] cnt  [2];
  logic [7:0] csel;
  logic [7:0] mlcc;
  always @(posedge clk)
  begin
    dev_rdata <= srst ? 8'h00 : ~dev_rdata;
    if (dev_wr && dev_index == 8'h1a)
      csel <= dev_wdata;
    if (dev_wr && dev_index == 8'h39)
      mlcc <= dev_wdata;
    for (int k = 0; k < 2; k++)
    begin
      if (srst)
      begin
        pos[k] <= 2'h0;
        p[k] <= 8'h00;
        cnt[k] <= 8'h00;
      end
      else
      begin
        if (dev_wr && dev_index == 8'h2c)
          pos[k] <= (dev_wdata == 8'h2a) ? 2'h2 :
                    (dev_wdata == 8'h3f) ? 2'h3 : 2'h0;
        if (dev_wr && dev_index == (k ? 8'h2f : 8'h2d))
        begin
          if (pos[k] == 2'h0)
            n6[k] <= dev_wdata[5:0];
          if (pos[k] == 2'h1)
            m[k] <= dev_wdata;
          if (pos[k] == 2'h2)
            p[k] <= dev_wdata;
          if (pos[k] != 2'h3)
            pos[k] <= (pos[k] == 2'h2) ? 2'h0 : pos[k] + 2'h1;
        end
        if (pll_sel[1] && !p[k][7])
          cnt[k] <= 8'h00;
        else if (pll_sel[1] && cnt[k] != 8'hff)
          cnt[k] <= cnt[k] + 8'h01;
        if (dev_rd && dev_index == (k ? 8'h2f : 8'h2d) && pos[k] == 2'h3)
          dev_rdata <= {1'b1, !hold_lock[k] &&
                        cnt[k] >= (slow ? SLOW_CYC : 1), 6'h15};
      end
    end
  end
endmodule : pemp_dev_model
`default_nettype wire

/* sim/pemp_host_chk.sv */
`include "pemp_params.svh"
`default_nettype none
module pemp_host_chk #(
  parameter int unsigned LOCK_TMO_CYC = 50
) (
  // clock and reset
  input wire logic                     clk,
  input wire logic                     srst,
  // user side
  input wire logic                     start,
  input wire pemp_pkg::pemp_depth_type depth_sel,
  input wire logic [8:0]               pix_mhz,
  input wire logic [7:0]               pix_n,
  input wire logic [7:0]               pix_m,
  input wire logic [1:0]               pix_p,
  input wire logic                     quiet_video_clock,
  input wire logic                     busy,
  input wire logic                     done,
  input wire logic                     fail,
  input wire logic                     fail_loop,
  // device side
  input wire logic [7:0]               dev_index,
  input wire logic [7:0]               dev_wdata,
  input wire logic                     dev_wr,
  input wire logic                     dev_rd,
  input wire logic [7:0]               dev_rdata,
  input wire logic [1:0]               pll_source_select_inputs
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] q_q, pp_q;
  logic       quiet_q, rdp_q;
  logic [7:0] ridx_q, lidx_q, lval_q, stop_q;
  always_ff @(posedge clk)
  begin
    if (start && !busy)
    begin
      q_q <= (pix_mhz >= `PEMP_BAND_HI) ? 2'h0 :
             (pix_mhz >= `PEMP_BAND_MID) ? 2'h1 :
             (pix_mhz >= `PEMP_BAND_LO) ? 2'h2 : 2'h3;
      pp_q <= pix_p;
      quiet_q <= quiet_video_clock;
    end
    rdp_q <= dev_rd && !srst;
    if (dev_rd)
      ridx_q <= dev_index;
    lidx_q <= srst ? 8'h00 : rdp_q ? ridx_q : lidx_q;
    lval_q <= srst ? 8'h00 : rdp_q ? dev_rdata : lval_q;
    stop_q <= (pll_source_select_inputs != 2'h3) ? 8'h00 :
              (stop_q == 8'hff) ? stop_q : stop_q + 8'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_clock_select: assert property (dev_wr && dev_index == 8'h1a |->
    dev_wdata == (quiet_q ? 8'h75 : 8'h05)) else $error("bad clock select");
  a_stop_order: assert property (dev_wr && dev_index == 8'h2c &&
    dev_wdata == 8'h2a |=> dev_wr && dev_index == 8'h2f && dev_wdata == 8'h00
    ##1 dev_wr && dev_index == 8'h2d && dev_wdata == 8'h00)
    else $error("bad stop order");
  a_stop_pins: assert property (dev_wr && dev_index == 8'h2d &&
    dev_wdata == 8'h00 |-> ##2 pll_source_select_inputs == 2'h3)
    else $error("select pins not 11");
  a_stop_wait: assert property (dev_wr && dev_index == 8'h2c &&
    dev_wdata == 8'h00 |-> stop_q >= `PEMP_STOP_CYC - 2)
    else $error("load before stop");
  a_n_top: assert property (dev_wr && (dev_index == 8'h2d ||
    dev_index == 8'h2f) &&
    $past(dev_wr && dev_index == 8'h2c && dev_wdata == 8'h00) |->
    dev_wdata[7:6] == 2'h3) else $error("n top bits");
  a_pix_load: assert property ((dev_wr && dev_index == 8'h2c &&
    dev_wdata == 8'h00) ##1 (dev_wr && dev_index == 8'h2d) |-> ##2
    dev_wr && dev_index == 8'h2d && dev_wdata == {6'h2c, pp_q})
    else $error("bad pixel p");
  a_loop_load: assert property ((dev_wr && dev_index == 8'h2c &&
    dev_wdata == 8'h00) ##1 (dev_wr && dev_index == 8'h2f) |-> ##2
    dev_wr && dev_index == 8'h2f && dev_wdata == {6'h3c, q_q})
    else $error("bad loop p");
  a_mlcc_band: assert property (dev_wr && dev_index == 8'h39 |->
    dev_wdata[2:0] == {1'b0, q_q} && lidx_q == 8'h2d && lval_q[6])
    else $error("bad post divider");
  a_done_lock: assert property (done |-> lidx_q == 8'h2f &&
    lval_q[6] && !$past(fail)) else $error("done without lock");
  a_busy_end: assert property ($fell(busy) |-> done || fail)
    else $error("busy fell early");
  c_done: cover property (done);
  c_fail_pix: cover property (fail && !fail_loop);
  c_fail_loop: cover property (fail && fail_loop);
endmodule : pemp_host_chk
bind pemp_host pemp_host_chk #(.LOCK_TMO_CYC(LOCK_TMO_CYC)) i_pemp_host_chk (
  .clk(clk), .srst(srst), .start(start), .depth_sel(depth_sel),
  .pix_mhz(pix_mhz), .pix_n(pix_n), .pix_m(pix_m), .pix_p(pix_p),
  .quiet_video_clock(quiet_video_clock), .busy(busy), .done(done),
  .fail(fail), .fail_loop(fail_loop), .dev_index(dev_index),
  .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd),
  .dev_rdata(dev_rdata),
  .pll_source_select_inputs(pll_source_select_inputs));
`default_nettype wire

/* sim/testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [1:0]  st;
    logic [54:0] regs;
  } pemp_exp_type;
  logic clk = 1'b0, srst = 1'b1, start = 1'b0, quiet = 1'b0, slow = 1'b0;
  logic [8:0] pix_mhz = 9'h000;
  logic [7:0] pix_n = 8'h00, pix_m = 8'h00, dev_index, dev_wdata, dev_rdata;
  logic [1:0] pix_p = 2'h0, hold_lock = 2'h0, sel;
  logic busy, done, fail, fail_loop, dev_wr, dev_rd;
  pemp_pkg::pemp_depth_type depth_sel = pemp_pkg::DEPTH_8;
  pemp_exp_type exp_q [$];
  pemp_exp_type e;
  int errors = 0, checked = 0;
  logic [7:0] ln_tab [4] = '{8'he1, 8'hf1, 8'hf9, 8'hf9};
  logic [7:0] lm_tab [4] = '{8'h3d, 8'h3d, 8'hbe, 8'h3d};
  always #2.5 clk = ~clk;
  pemp_host #(.LOCK_TMO_CYC(500)) i_pemp_host (.clk(clk), .srst(srst),
    .start(start), .depth_sel(depth_sel), .pix_mhz(pix_mhz), .pix_n(pix_n),
    .pix_m(pix_m), .pix_p(pix_p), .quiet_video_clock(quiet), .busy(busy),
    .done(done), .fail(fail), .fail_loop(fail_loop), .dev_index(dev_index),
    .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd),
    .dev_rdata(dev_rdata), .pll_source_select_inputs(sel));
  pemp_dev_model i_pemp_dev_model (.clk(clk), .srst(srst),
    .dev_index(dev_index), .dev_wdata(dev_wdata), .dev_wr(dev_wr),
    .dev_rd(dev_rd), .dev_rdata(dev_rdata), .pll_sel(sel),
    .hold_lock(hold_lock), .slow(slow));
  // ****************************************
  // compare and verdict
  // ****************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] expv);
    checked++;
    if (seen !== expv)
    begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, expv);
    end
  endtask : check
  task automatic give_verdict();
    if (errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  // ****************************************
  // one programming sequence
  // ****************************************
  task automatic run(input int d, input int mhz, input logic [1:0] hl,
                     input logic sl, input logic twice);
    logic [1:0] q;
    int n;
    @(posedge clk);
    #1;
    depth_sel = pemp_pkg::pemp_depth_type'(d);
    pix_mhz = 9'(mhz);
    pix_n = 8'($urandom);
    pix_m = 8'($urandom);
    pix_p = 2'($urandom);
    quiet = 1'($urandom);
    hold_lock = hl;
    slow = sl;
    start = 1'b1;
    q = (mhz >= 175) ? 2'h0 : (mhz >= 110) ? 2'h1 : (mhz >= 70) ? 2'h2 : 2'h3;
    e.st = hl[0] ? 2'h2 : hl[1] ? 2'h3 : 2'h0;
    e.regs = {quiet ? 8'h75 : 8'h05, pix_n[5:0], pix_m, 6'h2c, pix_p,
              ln_tab[d][5:0], lm_tab[d], 6'h3c, q, 1'b0, q};
    exp_q.push_back(e);
    @(posedge clk);
    #1;
    start = 1'b0;
    if (twice)
    begin
      repeat (10) @(posedge clk);
      #1 start = 1'b1;
      @(posedge clk);
      #1 start = 1'b0;
    end
    n = 0;
    while (!(done || fail) && n < 20000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 20000)
      check(64'h1, 64'h0);
  endtask : run
  // ****************************************
  // result watcher
  // ****************************************
  always @(negedge clk)
    if (!srst && (done || fail))
    begin
      if (exp_q.size() == 0)
        check(64'h1, 64'h0);
      else
      begin
        e = exp_q.pop_front();
        check({62'h0, fail, fail_loop}, {62'h0, e.st});
        if (done)
          check({9'h0, i_pemp_dev_model.csel, i_pemp_dev_model.n6[0],
                 i_pemp_dev_model.m[0], i_pemp_dev_model.p[0],
                 i_pemp_dev_model.n6[1], i_pemp_dev_model.m[1],
                 i_pemp_dev_model.p[1], i_pemp_dev_model.mlcc[2:0]},
                {9'h0, e.regs});
      end
    end
  initial
  begin
    #200000;
    errors++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(86199));
    repeat (12) @(posedge clk);
    #1 srst = 1'b0;
    run(0, 175, 2'h0, 1'b0, 1'b0);
    run(1, 174, 2'h0, 1'b1, 1'b1);
    run(2, 110, 2'h0, 1'b0, 1'b0);
    run(3, 69, 2'h0, 1'b1, 1'b0);
    repeat (3) run($urandom % 4, $urandom % 300, 2'h0, 1'b0, 1'b0);
    run(0, 100, 2'h1, 1'b0, 1'b0);
    run(1, 200, 2'h2, 1'b0, 1'b0);
    run(2, 70, 2'h0, 1'b0, 1'b0);
    repeat (5) @(posedge clk);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
